// [common/dgb_pkg.sv]
// Constants, types and helpers shared by the decimated gray-to-binary output.
// Assumes a single 250 MHz core clock; all slower rates are enable pulses.
package dgb_pkg;
   // Core clock rate, used to turn times into cycle counts
   localparam int CLOCK_MHZ = 250;
   // Longest invalid window of the ripple converter output, in ns
   localparam int GBC_INVALID_NS = 7;
   // Cycles to wait after capture before latching (least time, rounded up)
   localparam int GBC_SETTLE_RAW = (GBC_INVALID_NS * CLOCK_MHZ + 999) / 1000;
   localparam int GBC_SETTLE_CYC = (GBC_SETTLE_RAW < 1) ? 1 : GBC_SETTLE_RAW;
   // Decimation factors relative to the data-update rate
   localparam int DECIM_LOW0 = 16;
   localparam int DECIM_LOW1 = 32;
   localparam int DECIM_HIGH0 = 64;
   localparam int DECIM_HIGH1 = 128;
   // First-stage divide ratios
   localparam int STAGE1_DIV0 = 2;
   localparam int STAGE1_DIV1 = 4;
   // Forwarded clock high time in core cycles
   localparam int FWD_HIGH_CYC = 2;
   // Register map (word index on the plain register port)
   localparam int REG_ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_LAST = 4'h2;
   localparam logic [3:0] REG_COUNT = 4'h3;
   // Control field positions
   localparam int CTRL_LOW_BIT = 0;
   localparam int CTRL_HIGH_BIT = 1;
   localparam int CTRL_GROUP_BIT = 2;
   localparam int CTRL_S1DIV_BIT = 3;
   localparam int CTRL_INVERT_BIT = 4;
   localparam int CTRL_ENABLE_BIT = 5;
   localparam int CTRL_W = 6;
   // Control reset: group 1, factor 64, enabled
   localparam logic [5:0] CTRL_RESET = 6'h24;
   // Status field positions
   localparam int STAT_EMPTY_BIT = 0;
   localparam int STAT_FULL_BIT = 1;
   localparam int STAT_OVF_BIT = 2;
   localparam int STAT_LEVEL_LSB = 8;
   // Output stage states
   typedef enum logic [1:0] {OUT_IDLE, OUT_SETUP, OUT_HIGH} dgb_out_state_t;

   // Ripple gray-to-binary: top bit passes, each lower bit XORs the bit above
   function automatic logic [7:0] dgb_gray2bin(input logic [7:0] g);
      logic [7:0] b;
      b[7] = g[7];
      for (int i = 6; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // Total decimation factor chosen by the static selects
   function automatic int dgb_factor(input logic low, input logic high,
                                     input logic group);
      if (group) begin
         return high ? DECIM_HIGH1 : DECIM_HIGH0;
      end
      return low ? DECIM_LOW1 : DECIM_LOW0;
   endfunction
endpackage

// [common/dgb_stream_if.sv]
// Valid/ready word stream between the decimator core and its FIFO.
// Both ends sit on the same core clock.
`timescale 1ns/1ps
interface dgb_stream_if #(parameter int WIDTH = 8);
   logic valid; // Word offered
   logic ready; // Word accepted
   logic [WIDTH-1:0] data; // Word
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

// [verilog/dgb_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module dgb_fifo import dgb_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock, // Core clock
   input wire logic resetn, // Async reset, active low
   dgb_stream_if.snk wr, // Fill side
   dgb_stream_if.src rd, // Drain side
   output logic [$clog2(DEPTH):0] level // Words held
);
   localparam int AW = $clog2(DEPTH);
   // Pointers wrap on the power of two, so depth must be one
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("dgb_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW:0] wPtr_reg, wPtr_next; // Write pointer with wrap bit
   logic [AW:0] rPtr_reg, rPtr_next; // Read pointer with wrap bit
   logic doWrite, doRead;

   // Full and empty come straight from the pointers, never guessed
   assign level = wPtr_reg - rPtr_reg;
   assign wr.ready = (level != (AW+1)'(DEPTH));
   assign rd.valid = (level != '0);
   assign rd.data = mem[rPtr_reg[AW-1:0]];
   assign doWrite = wr.valid && wr.ready;
   assign doRead = rd.valid && rd.ready;

   // Pointer next values
   always_comb begin
      wPtr_next = doWrite ? wPtr_reg + 1'b1 : wPtr_reg;
      rPtr_next = doRead ? rPtr_reg + 1'b1 : rPtr_reg;
   end

   // Pointer registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wPtr_reg <= '0;
         rPtr_reg <= '0;
      end else begin
         wPtr_reg <= wPtr_next;
         rPtr_reg <= rPtr_next;
      end
   end

   // Storage has no reset; data is only read once written
   always_ff @(posedge clock) begin
      if (doWrite) begin
         mem[wPtr_reg[AW-1:0]] <= wr.data;
      end
   end

   a_fifo_no_overfill: assert property (@(posedge clock) disable iff (!resetn)
      level <= (AW+1)'(DEPTH)) else $error("FIFO level above depth");
endmodule // dgb_fifo

// [verilog/dgb_decim_out.sv]
// Second decimation stage, gray-to-binary converter, output latch, FIFO and
// forwarded differential clock for the decimated output and the DAC.
// Assumes gray words and data-ready arrive asynchronously from stage one.
`timescale 1ns/1ps

// Contract
// - Group 0: low select picks 16 or 32
// - Group 1: high select picks 64 or 128
// - Gray word in, equivalent binary word out
// - Top bit passes; lower bits ripple XOR
// - Converter output invalid up to 7 ns
// - Binary word latched after settling, then output
// - Differential forwarded clock, selectable phase
// - Decimated words also drive reconstruction DAC
// - Factor counted on data-update ready pulses
// - First stage divides by 2 or 4
module dgb_decim_out import dgb_pkg::*; #(
   parameter int FIFO_DEPTH = 32
) (
   clock, // Core clock, 250 MHz
   resetn, // Async reset, active low
   grayWordIn, // Gray word from stage one
   bankReadyIn, // Data-ready of the selected bank
   capReadyIn, // Capture instrument can take a word
   regAddr, // Register index
   regWData, // Register write data
   regWrite, // Write strobe
   regRead, // Read strobe
   regRData, // Read data, cycle after the read
   binaryWordOut, // Word to the output connector
   fwdClockPos, // Forwarded clock, true leg
   fwdClockNeg, // Forwarded clock, complement leg
   dacWord // Word to the reconstruction DAC
);
   input wire logic clock;
   input wire logic resetn;
   input wire logic [7:0] grayWordIn;
   input wire logic bankReadyIn;
   input wire logic capReadyIn;
   input wire logic [REG_ADDR_W-1:0] regAddr;
   input wire logic [31:0] regWData;
   input wire logic regWrite;
   input wire logic regRead;
   output logic [31:0] regRData;
   output logic [7:0] binaryWordOut;
   output logic fwdClockPos;
   output logic fwdClockNeg;
   output logic [7:0] dacWord;

   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam int SETTLE_D = GBC_SETTLE_CYC; // Delay used by the assertions
   initial begin
      if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin
         $error("dgb_decim_out: FIFO_DEPTH out of range");
      end
   end

   // Pin synchronisers: two flops, stage one read only by stage two
   logic [7:0] grayS1, grayS2;
   logic rdyS1, rdyS2, rdyS3;
   logic capS1, capS2;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         grayS1 <= 8'h00;
         grayS2 <= 8'h00;
         rdyS1 <= 1'b0;
         rdyS2 <= 1'b0;
         rdyS3 <= 1'b0;
         capS1 <= 1'b0;
         capS2 <= 1'b0;
      end else begin
         grayS1 <= grayWordIn;
         grayS2 <= grayS1;
         rdyS1 <= bankReadyIn;
         rdyS2 <= rdyS1;
         rdyS3 <= rdyS2;
         capS1 <= capReadyIn;
         capS2 <= capS1;
      end
   end

   // One pulse per data-update, at half the sample clock
   logic readyPulse;
   assign readyPulse = rdyS2 && !rdyS3;

   // Control register and its decoded fields
   logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic selLow, selHigh, selGroup, s1Div4, clkInvert, runEn;
   assign selLow = ctrl_reg[CTRL_LOW_BIT];
   assign selHigh = ctrl_reg[CTRL_HIGH_BIT];
   assign selGroup = ctrl_reg[CTRL_GROUP_BIT];
   assign s1Div4 = ctrl_reg[CTRL_S1DIV_BIT];
   assign clkInvert = ctrl_reg[CTRL_INVERT_BIT];
   assign runEn = ctrl_reg[CTRL_ENABLE_BIT];
   logic ctrlWr, statWr;
   assign ctrlWr = regWrite && (regAddr == REG_CTRL);
   assign statWr = regWrite && (regAddr == REG_STATUS);

   // Decimation targets: stage one ratio and the remainder for stage two
   logic [2:0] s1Div;
   logic [7:0] totalFactor, s2Target;
   always_comb begin
      s1Div = s1Div4 ? 3'(STAGE1_DIV1) : 3'(STAGE1_DIV0);
      totalFactor = 8'(dgb_factor(selLow, selHigh, selGroup));
      s2Target = 8'(totalFactor / s1Div);
   end

   // Decimation counters, gray capture and settle timer
   logic [1:0] s1Cnt_reg, s1Cnt_next;
   logic [7:0] s2Cnt_reg, s2Cnt_next;
   logic [7:0] grayHold_reg, grayHold_next;
   logic [1:0] settle_reg, settle_next;
   logic s1Tick, capPulse, latchPulse;
   always_comb begin
      s1Cnt_next = s1Cnt_reg;
      s2Cnt_next = s2Cnt_reg;
      grayHold_next = grayHold_reg;
      settle_next = settle_reg;
      s1Tick = 1'b0;
      capPulse = 1'b0;
      latchPulse = 1'b0;
      if (!runEn) begin
         // Stopped: restart both stages cleanly when enabled again
         s1Cnt_next = 2'd0;
         s2Cnt_next = 8'd0;
      end else if (readyPulse) begin
         // Wrap with >= so a select change never leaves a counter stranded
         if (3'(s1Cnt_reg) + 3'd1 >= s1Div) begin
            s1Cnt_next = 2'd0;
            s1Tick = 1'b1;
         end else begin
            s1Cnt_next = s1Cnt_reg + 2'd1;
         end
      end
      if (s1Tick) begin
         if (s2Cnt_reg + 8'd1 >= s2Target) begin
            s2Cnt_next = 8'd0;
            capPulse = 1'b1;
         end else begin
            s2Cnt_next = s2Cnt_reg + 8'd1;
         end
      end
      if (capPulse) begin
         grayHold_next = grayS2;
         settle_next = 2'(GBC_SETTLE_CYC);
      end else if (settle_reg != 2'd0) begin
         // Latch only once the ripple path has settled
         settle_next = settle_reg - 2'd1;
         latchPulse = (settle_reg == 2'd1);
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s1Cnt_reg <= 2'd0;
         s2Cnt_reg <= 8'd0;
         grayHold_reg <= 8'h00;
         settle_reg <= 2'd0;
      end else begin
         s1Cnt_reg <= s1Cnt_next;
         s2Cnt_reg <= s2Cnt_next;
         grayHold_reg <= grayHold_next;
         settle_reg <= settle_next;
      end
   end

   // Ripple converter on the held gray word
   logic [7:0] convBin;
   assign convBin = dgb_gray2bin(grayHold_reg);

   // FIFO between the latch and the output connector
   dgb_stream_if #(.WIDTH(8)) fillIf();
   dgb_stream_if #(.WIDTH(8)) drainIf();
   logic [LW-1:0] fifoLevel;
   assign fillIf.valid = latchPulse;
   assign fillIf.data = convBin;
   dgb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .resetn(resetn),
      .wr(fillIf.snk),
      .rd(drainIf.src),
      .level(fifoLevel)
   );

   // Output latch, overflow flag and delivered-word count
   logic [7:0] lastBin_reg, lastBin_next;
   logic ovf_reg, ovf_next;
   logic [15:0] count_reg, count_next;
   logic popWord;
   always_comb begin
      lastBin_next = latchPulse ? convBin : lastBin_reg;
      // A stream cannot be stalled, so a full FIFO drops and flags; set wins
      ovf_next = ovf_reg;
      if (statWr && regWData[STAT_OVF_BIT]) begin
         ovf_next = 1'b0;
      end
      if (latchPulse && !fillIf.ready) begin
         ovf_next = 1'b1;
      end
      count_next = popWord ? count_reg + 16'd1 : count_reg;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lastBin_reg <= 8'h00;
         ovf_reg <= 1'b0;
         count_reg <= 16'h0000;
      end else begin
         lastBin_reg <= lastBin_next;
         ovf_reg <= ovf_next;
         count_reg <= count_next;
      end
   end

   // Output stage: word first, then the forwarded clock edge, then hold
   dgb_out_state_t oState_reg, oState_next;
   logic [1:0] hiCnt_reg, hiCnt_next;
   logic [7:0] outWord_reg, outWord_next;
   logic fwdPos_reg, fwdPos_next;
   assign popWord = (oState_reg == OUT_IDLE) && drainIf.valid && capS2;
   assign drainIf.ready = popWord;
   always_comb begin
      oState_next = oState_reg;
      hiCnt_next = hiCnt_reg;
      outWord_next = outWord_reg;
      unique case (oState_reg)
         OUT_IDLE: begin
            if (popWord) begin
               outWord_next = drainIf.data;
               oState_next = OUT_SETUP;
            end
         end
         OUT_SETUP: begin
            // One cycle of setup before the clock rises
            hiCnt_next = 2'(FWD_HIGH_CYC - 1);
            oState_next = OUT_HIGH;
         end
         OUT_HIGH: begin
            if (hiCnt_reg == 2'd0) begin
               oState_next = OUT_IDLE;
            end else begin
               hiCnt_next = hiCnt_reg - 2'd1;
            end
         end
      endcase
      fwdPos_next = (oState_next == OUT_HIGH) ^ clkInvert;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         oState_reg <= OUT_IDLE;
         hiCnt_reg <= 2'd0;
         outWord_reg <= 8'h00;
         fwdPos_reg <= 1'b0;
      end else begin
         oState_reg <= oState_next;
         hiCnt_reg <= hiCnt_next;
         outWord_reg <= outWord_next;
         fwdPos_reg <= fwdPos_next;
      end
   end
   assign binaryWordOut = outWord_reg;
   assign dacWord = outWord_reg;
   assign fwdClockPos = fwdPos_reg;
   assign fwdClockNeg = !fwdPos_reg;

   // Register file: control write, read data one cycle after the strobe
   logic [31:0] rData_reg, rData_next;
   always_comb begin
      ctrl_next = ctrlWr ? regWData[CTRL_W-1:0] : ctrl_reg;
      rData_next = 32'h0000_0000;
      if (regRead) begin
         unique case (regAddr)
            REG_CTRL: rData_next = {26'd0, ctrl_reg};
            REG_STATUS: begin
               rData_next[STAT_EMPTY_BIT] = !drainIf.valid;
               rData_next[STAT_FULL_BIT] = !fillIf.ready;
               rData_next[STAT_OVF_BIT] = ovf_reg;
               rData_next[STAT_LEVEL_LSB +: LW] = fifoLevel;
            end
            REG_LAST: rData_next = {24'd0, lastBin_reg};
            REG_COUNT: rData_next = {16'd0, count_reg};
            default: rData_next = 32'h0000_0000; // Unmapped reads as zero
         endcase
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= CTRL_RESET;
         rData_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         rData_reg <= rData_next;
      end
   end
   assign regRData = rData_reg;

   // Assertion helpers: ready pulses since last capture, quiet config
   logic [7:0] sinceCap_reg;
   logic seenCap_reg, quiet_reg;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sinceCap_reg <= 8'd0;
         seenCap_reg <= 1'b0;
         quiet_reg <= 1'b0;
      end else begin
         sinceCap_reg <= capPulse ? 8'd0 : sinceCap_reg + 8'(readyPulse);
         seenCap_reg <= seenCap_reg | capPulse;
         quiet_reg <= ctrlWr ? 1'b0 : (quiet_reg | capPulse);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_captured; capPulse; endsequence
   // Latch comes exactly one settle time after the capture, and the word is kept
   sequence s_settled;
      $past(capPulse, SETTLE_D) ##1 lastBin_reg == $past(convBin);
   endsequence
   a_factor_low: assert property (capPulse && seenCap_reg && quiet_reg
      && !selGroup |-> sinceCap_reg == 8'((selLow ? DECIM_LOW1 : DECIM_LOW0) - 1))
      else $error("Low group capture spacing wrong");
   a_factor_high: assert property (capPulse && seenCap_reg && quiet_reg
      && selGroup |-> sinceCap_reg == 8'((selHigh ? DECIM_HIGH1 : DECIM_HIGH0) - 1))
      else $error("High group capture spacing wrong");
   a_conv_inverse: assert property ((convBin ^ (convBin >> 1)) == grayHold_reg)
      else $error("Binary word is not the gray equivalent");
   a_conv_ripple: assert property (convBin[7] == grayHold_reg[7]
      && convBin[0] == (convBin[1] ^ grayHold_reg[0]))
      else $error("Ripple relation broken");
   // Captures are many ready pulses apart, so the settle timer is never reloaded
   a_latch_settle: assert property (s_captured |-> ##SETTLE_D latchPulse)
      else $error("Latch not after settle time");
   a_latch_value: assert property (latchPulse |-> s_settled)
      else $error("Latched word not the converter output");
   a_fwd_pair: assert property (fwdClockNeg != fwdClockPos
      && (oState_reg == OUT_HIGH) == (fwdClockPos ^ $past(clkInvert)))
      else $error("Forwarded clock legs or phase wrong");
   a_dac_follow: assert property (popWord |=> dacWord == $past(drainIf.data)
      ##1 $stable(dacWord) [*2]) else $error("DAC word not held with output");
   a_s1_ratio: assert property (s1Tick |-> 3'(s1Cnt_reg) == s1Div - 3'd1)
      else $error("First stage divide wrong");
   a_hold_stable: assert property (!capPulse |=> $stable(grayHold_reg))
      else $error("Held gray word changed without capture");
endmodule // dgb_decim_out

// [tb/dgb_capture_model.sv]
// Capture instrument model on the decimated output connector.
// Assumes the core clock; the bench tells it which forwarded phase is true.
`timescale 1ns/1ps
module dgb_capture_model (
   input wire logic clock, // Core clock
   input wire logic resetn, // Async reset, active low
   input wire logic hold, // Refuse every word
   input wire logic slow, // Take words in bursts only
   input wire logic invert, // Forwarded clock runs inverted
   input wire logic armed, // Capture enabled
   input wire logic fwdClockPos, // Forwarded clock, true leg
   input wire logic [7:0] binaryWordOut, // Connector word
   input wire logic [7:0] dacWord, // DAC word
   output logic capReadyIn, // Ready toward the block
   output logic capStrobe, // One cycle per captured word
   output logic [7:0] capWord, // Captured connector word
   output logic [7:0] capDac // DAC word seen at the same edge
);
   logic [2:0] pace_reg; // Burst pacing counter
   logic prev_reg; // True phase one cycle ago
   wire logic truePhase = fwdClockPos ^ invert; // Rising edge means data valid
   wire logic hit = armed && truePhase && !prev_reg; // Forwarded edge seen
   // Ready pacing: a slow instrument stalls half of the time
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pace_reg <= 3'h0;
         capReadyIn <= 1'b0;
      end else begin
         pace_reg <= pace_reg + 3'h1;
         capReadyIn <= !hold && (!slow || pace_reg[2]);
      end
   end
   // Sample only at the forwarded edge, clear of the converter's unsettled time
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prev_reg <= 1'b0;
         capStrobe <= 1'b0;
         capWord <= 8'h00;
         capDac <= 8'h00;
      end else begin
         prev_reg <= truePhase;
         capStrobe <= hit;
         if (hit) begin
            capWord <= binaryWordOut;
            capDac <= dacWord;
         end
      end
   end
endmodule // dgb_capture_model

// [tb/tb_top.sv]
// Self-checking bench for the decimated gray-to-binary output.
// Assumes the capture model on the connector and a 250 MHz core clock.
`timescale 1ns/1ps
module tb_top import dgb_pkg::*;;
   logic clock = 1'b0; // Core clock
   logic resetn = 1'b0; // Async reset
   logic [7:0] grayWordIn = 8'h00; // Gray word from stage one
   logic bankReadyIn = 1'b0; // Data-ready pulses
   logic [3:0] regAddr = 4'h0; // Register index
   logic [31:0] regWData = 32'h0000_0000; // Write data
   logic regWrite = 1'b0; // Write strobe
   logic regRead = 1'b0; // Read strobe
   logic hold = 1'b0; // Instrument refuses words
   logic slow = 1'b0; // Instrument stalls
   logic invert = 1'b0; // Expected clock phase
   logic armed = 1'b1; // Instrument captures
   wire logic capReadyIn, fwdClockPos, fwdClockNeg, capStrobe;
   wire logic [31:0] regRData;
   wire logic [7:0] binaryWordOut, dacWord, capWord, capDac;
   logic [7:0] expQ[$]; // Words expected at the connector
   logic [7:0] expWord; // Oldest expectation
   logic [7:0] lastBin = 8'h00; // Last word sent
   logic [31:0] lfsr = 32'h0000_227f; // Random source
   int nErrors = 0;
   int numChecks = 0;
   always #2 clock = ~clock; // 4 ns period
   dgb_decim_out #(.FIFO_DEPTH(32)) u_dgb_decim_out (
      .clock(clock), .resetn(resetn), .grayWordIn(grayWordIn),
      .bankReadyIn(bankReadyIn), .capReadyIn(capReadyIn), .regAddr(regAddr),
      .regWData(regWData), .regWrite(regWrite), .regRead(regRead),
      .regRData(regRData), .binaryWordOut(binaryWordOut),
      .fwdClockPos(fwdClockPos), .fwdClockNeg(fwdClockNeg), .dacWord(dacWord));
   dgb_capture_model u_dgb_capture_model (
      .clock(clock), .resetn(resetn), .hold(hold), .slow(slow),
      .invert(invert), .armed(armed), .fwdClockPos(fwdClockPos),
      .binaryWordOut(binaryWordOut), .dacWord(dacWord),
      .capReadyIn(capReadyIn), .capStrobe(capStrobe), .capWord(capWord),
      .capDac(capDac));
   // Shift register step for random gray words
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Each binary bit is the parity of the gray bits at and above it
   function automatic logic [7:0] toBin(input logic [7:0] g);
      logic [7:0] b;
      for (int i = 0; i < 8; i++) begin
         b[i] = ^(g >> i);
      end
      return b;
   endfunction
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic finishTest();
      $display("Checks %0d, mismatches %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Register write: one strobe cycle
   task automatic regWr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   // Register read: data only in the cycle after the strobe
   task automatic regChk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      check(regRData, e);
   endtask
   // Quiet the instrument while the selects and the phase change
   task automatic cfg(input logic [4:0] c);
      armed <= 1'b0;
      regWr(REG_CTRL, 32'(c));
      repeat (6) @(posedge clock);
      invert <= c[4];
      repeat (2) @(posedge clock);
      armed <= 1'b1;
      regWr(REG_CTRL, 32'(c) | 32'h0000_0020);
   endtask
   // One decimated word: gray held over all n ready pulses of its period
   task automatic sendWord(input int n, input logic keep);
      logic [7:0] g;
      lfsr = nextRand(lfsr);
      g = lfsr[7:0];
      if (keep) begin
         expQ.push_back(toBin(g));
         lastBin = toBin(g);
      end
      @(posedge clock);
      grayWordIn <= g;
      repeat (n) begin
         @(posedge clock);
         bankReadyIn <= 1'b1;
         repeat (4) @(posedge clock);
         bankReadyIn <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask
   // Bounded wait until every expected word came out
   task automatic waitDrain();
      for (int i = 0; i < 4000 && expQ.size() > 0; i++) begin
         @(posedge clock);
      end
      if (expQ.size() > 0) begin
         check(32'(expQ.size()), 32'h0000_0000);
         finishTest();
      end else begin
         repeat (8) @(posedge clock);
      end
   endtask
   // Output watcher: legs stay complementary; each capture meets the oldest note
   // Sampled mid-cycle so that registered outputs have settled
   always @(negedge clock) begin
      if (resetn) begin
         check(32'(fwdClockNeg), 32'(!fwdClockPos));
      end
      if (capStrobe) begin
         check(32'(expQ.size() > 0), 32'h0000_0001);
         if (expQ.size() > 0) begin
            expWord = expQ.pop_front();
            check(32'(capWord), 32'(expWord));
            check(32'(capDac), 32'(expWord));
         end
      end
   end
   // Hang guard
   initial begin
      repeat (60000) @(posedge clock);
      check(32'h0000_0000, 32'h0000_0001);
      finishTest();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      #1;
      check(32'({binaryWordOut, dacWord, fwdClockPos, fwdClockNeg}), 32'h0000_0001);
      regChk(REG_CTRL, 32'h0000_0024);
      regChk(4'h7, 32'h0000_0000);
      regChk(REG_STATUS, 32'h0000_0001);
      @(posedge clock);
      #1;
      check(regRData, 32'h0000_0000);
      $display("Test reset done");
      // Every factor, both stage-one ratios, both phases; unused select random
      for (int i = 0; i < 4; i++) begin
         lfsr = nextRand(lfsr);
         slow <= i[1];
         cfg({i[1] ^ i[0], i[0], i[1], i[1] ? i[0] : lfsr[0], i[1] ? lfsr[1] : i[0]});
         repeat (2) sendWord(16 << i, 1'b1);
         waitDrain();
      end
      regChk(REG_LAST, 32'(lastBin));
      $display("Test factors done");
      // Fill past 32 words with the instrument refusing, then drain slowly
      cfg(5'h00);
      hold <= 1'b1;
      repeat (32) sendWord(16, 1'b1);
      sendWord(16, 1'b0);
      repeat (8) @(posedge clock);
      regChk(REG_STATUS, 32'h0000_2006);
      hold <= 1'b0;
      waitDrain();
      regChk(REG_STATUS, 32'h0000_0005);
      regWr(REG_STATUS, 32'h0000_0004);
      regChk(REG_STATUS, 32'h0000_0001);
      regChk(REG_COUNT, 32'h0000_0028);
      $display("Test fifo done");
      finishTest();
   end
endmodule // tb_top
